// >>> hw/bfc_pkg.sv
// Contract
// [RQ1] Indirect jump loads the PC with Z in 2 cycles and keeps all flags.
// [RQ2] Extended jump to page:Z in 2 cycles, absolute in 3, flags kept.
// [RQ3] Relative call to PC plus offset plus one in 4 cycles, flags kept.
// [RQ4] Indirect call to Z, extended to page:Z, 4 cycles; absolute call 5.
// [RQ5] Equal-compare-skip skips 2 or 3 words on a match, 1/2/3 cycles. The code adds 2 or 3 to the PC, skipping 1 or 2 words.
// [RQ6] Compares subtract without storing and set Z N V C H in 1 cycle.
// [RQ7] Register-bit skips skip the next instruction if met, 1/2/3 cycles.
// [RQ8] I/O-bit skips add 2 or 3 to the PC if met, 1/2/3 cycles.
// [RQ9] Flag branches test the flag a 3-bit selector picks, target PC+k+1.
// [RQ10] Branch on equal is taken on Z 1, not-equal on Z 0, 1 or 2 cycles.
// [RQ11] Carry-high, lower taken on C 1; carry-low, same-or-higher on C 0.
// [RQ12] Negative taken on N 1, positive on N 0; 1 cycle untaken, 2 taken.
// [RQ13] Signed greater-or-equal taken on N xor V 0, signed less-than on 1.
// [RQ14] Half-carry-high taken on H 1, half-carry-low on H 0, 1 or 2 cycles.
// [RQ15] T-bit-high taken on T 1, T-bit-low on T 0, 1 or 2 cycles.
// [RQ16] Exits pop the PC from the stack in 5 cycles; interrupt exit sets I.
// [RQ17] Skip or taken branch adds a cycle, +1 for two words; flags kept.
package bfc_pkg;

    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int FlagC = 0;
    localparam int FlagZ = 1;
    localparam int FlagN = 2;
    localparam int FlagV = 3;
    localparam int FlagS = 4;
    localparam int FlagH = 5;
    localparam int FlagT = 6;
    localparam int FlagI = 7;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0] CycIndJump = 3'h2;
    localparam logic [2:0] CycAbsJump = 3'h3;
    localparam logic [2:0] CycCallShort = 3'h4;
    localparam logic [2:0] CycCallAbs = 3'h5;
    localparam logic [2:0] CycExit = 3'h5;
    localparam logic [2:0] CycBase = 3'h1;
    localparam logic [2:0] CycOneWordSkip = 3'h2;
    localparam logic [2:0] CycTwoWordSkip = 3'h3;
    localparam logic [2:0] CycTaken = 3'h2;

    // ------------------------------------------------------------
    // Program counter steps
    // ------------------------------------------------------------
    localparam int StepNext = 1;
    localparam int StepSkipOne = 2;
    localparam int StepSkipTwo = 3;
    localparam int StepAbsCallRet = 2;
    localparam int PcResetVal = 0;

    typedef enum logic [5:0] {
        OP_REG_INDIRECT_JUMP,
        OP_EXTENDED_INDIRECT_JUMP,
        OP_ABSOLUTE_JUMP,
        OP_RELATIVE_SUBROUTINE_ENTRY,
        OP_INDIRECT_SUBROUTINE_ENTRY,
        OP_EXTENDED_SUBROUTINE_ENTRY,
        OP_ABSOLUTE_SUBROUTINE_ENTRY,
        OP_SUBROUTINE_EXIT,
        OP_INTERRUPT_EXIT,
        OP_EQUAL_COMPARE_SKIP,
        OP_COMPARE_REGISTERS,
        OP_COMPARE_WITH_BORROW,
        OP_COMPARE_CONSTANT,
        OP_SKIP_REG_BIT_LOW,
        OP_SKIP_REG_BIT_HIGH,
        OP_SKIP_IO_BIT_LOW,
        OP_SKIP_IO_BIT_HIGH,
        OP_BRANCH_FLAG_HIGH,
        OP_BRANCH_FLAG_LOW,
        OP_BRANCH_ON_EQUAL,
        OP_BRANCH_NOT_EQUAL,
        OP_BRANCH_CARRY_HIGH,
        OP_BRANCH_CARRY_LOW,
        OP_BRANCH_SAME_HIGHER,
        OP_BRANCH_LOWER,
        OP_BRANCH_NEGATIVE,
        OP_BRANCH_POSITIVE,
        OP_BRANCH_GE_SIGNED,
        OP_BRANCH_LT_SIGNED,
        OP_BRANCH_HALFCARRY_HIGH,
        OP_BRANCH_HALFCARRY_LOW,
        OP_BRANCH_TBIT_HIGH,
        OP_BRANCH_TBIT_LOW
    } bfc_op_t;

    // Decoded instruction from the core
    typedef struct packed {
        bfc_op_t op;
        logic [7:0] regD;
        logic [7:0] regR;
        logic [7:0] constVal;
        logic [11:0] offset;
        logic [21:0] target;
        logic [2:0] bitSel;
        logic ioBit;
        logic nextTwoWord;
    } bfc_cmd_t;

    // Outcome handed back to the core
    typedef struct packed {
        logic [21:0] newPc;
        logic [21:0] retAddr;
        logic [7:0] flags;
        logic flagsWrite;
        logic pushRet;
        logic popRet;
        logic [2:0] cycles;
    } bfc_res_t;

endpackage

// >>> hw/bfc_compare_unit.sv
`timescale 1ns/1ps
module bfc_compare_unit
(
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic useCarry,
    input wire logic [7:0] flagsIn,
    output logic [7:0] flagsOut
);

    logic [8:0] diff;
    logic [4:0] lowDiff;
    logic borrowIn;
    logic zeroNow;

    always_comb
    begin
        borrowIn = useCarry & flagsIn[bfc_pkg::FlagC];
        diff = {1'b0, opA} - {1'b0, opB} - {8'h00, borrowIn};
        lowDiff = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, borrowIn};
        // Carry-chained compare keeps zero only if it was already set
        zeroNow = (diff[7:0] == 8'h00) &
            (~useCarry | flagsIn[bfc_pkg::FlagZ]);
        flagsOut = flagsIn;
        flagsOut[bfc_pkg::FlagC] = diff[8]; // RQ6
        flagsOut[bfc_pkg::FlagZ] = zeroNow;
        flagsOut[bfc_pkg::FlagN] = diff[7];
        flagsOut[bfc_pkg::FlagV] = (opA[7] & ~opB[7] & ~diff[7]) |
            (~opA[7] & opB[7] & diff[7]);
        flagsOut[bfc_pkg::FlagH] = lowDiff[4];
    end

endmodule

// >>> hw/bfc_flow_unit.sv
`timescale 1ns/1ps
module bfc_flow_unit
#(
    parameter int PcW = 22
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire bfc_pkg::bfc_cmd_t cmd,
    input wire logic [PcW-1:0] pc,
    input wire logic [15:0] zPtr,
    input wire logic [7:0] extendedJumpPage,
    input wire logic [7:0] statusFlagsRegister,
    input wire logic [PcW-1:0] stackAddr,
    output logic busy_ff,
    output logic done_ff,
    output bfc_pkg::bfc_res_t res_ff
);

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } bfc_state_t;

    bfc_state_t state_ff;
    bfc_state_t nxt_state;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic nxt_busy;
    logic nxt_done;
    bfc_pkg::bfc_res_t nxt_res;

    // ------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------
    logic [7:0] cmpFlags;
    logic [7:0] cmpB;
    logic cmpCarry;
    logic [PcW-1:0] relTarget;
    logic [PcW-1:0] extTarget;
    logic [23:0] extWide;
    logic condOk;
    logic isSkip;
    logic isBranch;
    logic flagBit;

    bfc_compare_unit u_cmp
    (
        .opA(cmd.regD),
        .opB(cmpB),
        .useCarry(cmpCarry),
        .flagsIn(statusFlagsRegister),
        .flagsOut(cmpFlags)
    );

    always_comb
    begin
        cmpB = (cmd.op == bfc_pkg::OP_COMPARE_CONSTANT) ?
            cmd.constVal : cmd.regR;
        cmpCarry = (cmd.op == bfc_pkg::OP_COMPARE_WITH_BORROW);
        relTarget = pc + PcW'(bfc_pkg::StepNext) +
            PcW'({{(PcW-12){cmd.offset[11]}}, cmd.offset});
        extWide = {extendedJumpPage, zPtr};
        extTarget = extWide[PcW-1:0];
        flagBit = statusFlagsRegister[cmd.bitSel];
        isSkip = 1'b0;
        isBranch = 1'b0;
        condOk = 1'b0;
        case (cmd.op)
            bfc_pkg::OP_EQUAL_COMPARE_SKIP:
            begin
                isSkip = 1'b1;
                condOk = (cmd.regD == cmd.regR); // RQ5
            end
            bfc_pkg::OP_SKIP_REG_BIT_LOW:
            begin
                isSkip = 1'b1;
                condOk = ~cmd.regR[cmd.bitSel]; // RQ7
            end
            bfc_pkg::OP_SKIP_REG_BIT_HIGH:
            begin
                isSkip = 1'b1;
                condOk = cmd.regR[cmd.bitSel]; // RQ7
            end
            bfc_pkg::OP_SKIP_IO_BIT_LOW:
            begin
                isSkip = 1'b1;
                condOk = ~cmd.ioBit; // RQ8
            end
            bfc_pkg::OP_SKIP_IO_BIT_HIGH:
            begin
                isSkip = 1'b1;
                condOk = cmd.ioBit; // RQ8
            end
            bfc_pkg::OP_BRANCH_FLAG_HIGH:
            begin
                isBranch = 1'b1;
                condOk = flagBit; // RQ9
            end
            bfc_pkg::OP_BRANCH_FLAG_LOW:
            begin
                isBranch = 1'b1;
                condOk = ~flagBit; // RQ9
            end
            bfc_pkg::OP_BRANCH_ON_EQUAL:
            begin
                isBranch = 1'b1;
                condOk = statusFlagsRegister[bfc_pkg::FlagZ]; // RQ10
            end
            bfc_pkg::OP_BRANCH_NOT_EQUAL:
            begin
                isBranch = 1'b1;
                condOk = ~statusFlagsRegister[bfc_pkg::FlagZ]; // RQ10
            end
            bfc_pkg::OP_BRANCH_CARRY_HIGH, bfc_pkg::OP_BRANCH_LOWER:
            begin
                isBranch = 1'b1;
                condOk = statusFlagsRegister[bfc_pkg::FlagC]; // RQ11
            end
            bfc_pkg::OP_BRANCH_CARRY_LOW, bfc_pkg::OP_BRANCH_SAME_HIGHER:
            begin
                isBranch = 1'b1;
                condOk = ~statusFlagsRegister[bfc_pkg::FlagC]; // RQ11
            end
            bfc_pkg::OP_BRANCH_NEGATIVE:
            begin
                isBranch = 1'b1;
                condOk = statusFlagsRegister[bfc_pkg::FlagN]; // RQ12
            end
            bfc_pkg::OP_BRANCH_POSITIVE:
            begin
                isBranch = 1'b1;
                condOk = ~statusFlagsRegister[bfc_pkg::FlagN]; // RQ12
            end
            bfc_pkg::OP_BRANCH_GE_SIGNED:
            begin
                isBranch = 1'b1;
                condOk = ~(statusFlagsRegister[bfc_pkg::FlagN] ^
                    statusFlagsRegister[bfc_pkg::FlagV]); // RQ13
            end
            bfc_pkg::OP_BRANCH_LT_SIGNED:
            begin
                isBranch = 1'b1;
                condOk = statusFlagsRegister[bfc_pkg::FlagN] ^
                    statusFlagsRegister[bfc_pkg::FlagV]; // RQ13
            end
            bfc_pkg::OP_BRANCH_HALFCARRY_HIGH:
            begin
                isBranch = 1'b1;
                condOk = statusFlagsRegister[bfc_pkg::FlagH]; // RQ14
            end
            bfc_pkg::OP_BRANCH_HALFCARRY_LOW:
            begin
                isBranch = 1'b1;
                condOk = ~statusFlagsRegister[bfc_pkg::FlagH]; // RQ14
            end
            bfc_pkg::OP_BRANCH_TBIT_HIGH:
            begin
                isBranch = 1'b1;
                condOk = statusFlagsRegister[bfc_pkg::FlagT]; // RQ15
            end
            bfc_pkg::OP_BRANCH_TBIT_LOW:
            begin
                isBranch = 1'b1;
                condOk = ~statusFlagsRegister[bfc_pkg::FlagT]; // RQ15
            end
            default:
            begin
                isSkip = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_res = res_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (start)
                begin
                    // Flow ops other than the compares and the interrupt exit echo the flags untouched
                    nxt_res.flags = statusFlagsRegister; // RQ17
                    nxt_res.flagsWrite = 1'b0;
                    nxt_res.pushRet = 1'b0;
                    nxt_res.popRet = 1'b0;
                    nxt_res.retAddr = pc + PcW'(bfc_pkg::StepNext);
                    nxt_res.newPc = pc + PcW'(bfc_pkg::StepNext);
                    nxt_res.cycles = bfc_pkg::CycBase;
                    case (cmd.op)
                        bfc_pkg::OP_REG_INDIRECT_JUMP:
                        begin
                            nxt_res.newPc = PcW'(zPtr); // RQ1
                            nxt_res.cycles = bfc_pkg::CycIndJump;
                        end
                        bfc_pkg::OP_EXTENDED_INDIRECT_JUMP:
                        begin
                            nxt_res.newPc = extTarget; // RQ2
                            nxt_res.cycles = bfc_pkg::CycIndJump;
                        end
                        bfc_pkg::OP_ABSOLUTE_JUMP:
                        begin
                            nxt_res.newPc = cmd.target[PcW-1:0]; // RQ2
                            nxt_res.cycles = bfc_pkg::CycAbsJump;
                        end
                        bfc_pkg::OP_RELATIVE_SUBROUTINE_ENTRY:
                        begin
                            nxt_res.newPc = relTarget; // RQ3
                            nxt_res.pushRet = 1'b1;
                            nxt_res.cycles = bfc_pkg::CycCallShort;
                        end
                        bfc_pkg::OP_INDIRECT_SUBROUTINE_ENTRY:
                        begin
                            nxt_res.newPc = PcW'(zPtr); // RQ4
                            nxt_res.pushRet = 1'b1;
                            nxt_res.cycles = bfc_pkg::CycCallShort;
                        end
                        bfc_pkg::OP_EXTENDED_SUBROUTINE_ENTRY:
                        begin
                            nxt_res.newPc = extTarget; // RQ4
                            nxt_res.pushRet = 1'b1;
                            nxt_res.cycles = bfc_pkg::CycCallShort;
                        end
                        bfc_pkg::OP_ABSOLUTE_SUBROUTINE_ENTRY:
                        begin
                            nxt_res.newPc = cmd.target[PcW-1:0]; // RQ4
                            nxt_res.pushRet = 1'b1;
                            nxt_res.retAddr =
                                pc + PcW'(bfc_pkg::StepAbsCallRet);
                            nxt_res.cycles = bfc_pkg::CycCallAbs;
                        end
                        bfc_pkg::OP_SUBROUTINE_EXIT:
                        begin
                            nxt_res.newPc = stackAddr; // RQ16
                            nxt_res.popRet = 1'b1;
                            nxt_res.cycles = bfc_pkg::CycExit;
                        end
                        bfc_pkg::OP_INTERRUPT_EXIT:
                        begin
                            nxt_res.newPc = stackAddr; // RQ16
                            nxt_res.popRet = 1'b1;
                            nxt_res.flags[bfc_pkg::FlagI] = 1'b1; // RQ16
                            nxt_res.flagsWrite = 1'b1;
                            nxt_res.cycles = bfc_pkg::CycExit;
                        end
                        bfc_pkg::OP_COMPARE_REGISTERS,
                        bfc_pkg::OP_COMPARE_WITH_BORROW,
                        bfc_pkg::OP_COMPARE_CONSTANT:
                        begin
                            nxt_res.flags = cmpFlags; // RQ6
                            nxt_res.flagsWrite = 1'b1;
                        end
                        default:
                        begin
                            if (isSkip && condOk && cmd.nextTwoWord)
                            begin
                                nxt_res.newPc =
                                    pc + PcW'(bfc_pkg::StepSkipTwo);
                                nxt_res.cycles = bfc_pkg::CycTwoWordSkip;
                            end
                            else if (isSkip && condOk)
                            begin
                                nxt_res.newPc =
                                    pc + PcW'(bfc_pkg::StepSkipOne);
                                nxt_res.cycles = bfc_pkg::CycOneWordSkip;
                            end
                            else if (isBranch && condOk)
                            begin
                                nxt_res.newPc = relTarget; // RQ17
                                nxt_res.cycles = bfc_pkg::CycTaken;
                            end
                        end
                    endcase
                    if (nxt_res.cycles == bfc_pkg::CycBase)
                    begin
                        nxt_done = 1'b1;
                    end
                    else
                    begin
                        nxt_state = ST_EXEC;
                        nxt_busy = 1'b1;
                        nxt_cnt = nxt_res.cycles - 3'h1;
                    end
                end
            end
            ST_EXEC:
            begin
                nxt_cnt = cnt_ff - 3'h1;
                if (cnt_ff == 3'h1)
                begin
                    nxt_done = 1'b1;
                    nxt_busy = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 3'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            res_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            res_ff <= nxt_res;
        end
    end

endmodule

// >>> verification/bfc_flow_checker.sv
`timescale 1ns/1ps
module bfc_flow_checker
#(
    parameter int PcW = 22
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic start,
    input wire bfc_pkg::bfc_cmd_t cmd,
    input wire logic [PcW-1:0] pc,
    input wire logic [15:0] zPtr,
    input wire logic [7:0] extendedJumpPage,
    input wire logic [7:0] statusFlagsRegister,
    input wire logic [PcW-1:0] stackAddr,
    input wire logic busy_ff,
    input wire logic done_ff,
    input wire bfc_pkg::bfc_res_t res_ff
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    logic isTake;
    assign isTake = start && !busy_ff;

    // ----------------------------------------
    // Flow checks
    // ----------------------------------------
    ind_jump_pc_a: assert property (
        isTake && cmd.op == bfc_pkg::OP_REG_INDIRECT_JUMP |=>
        res_ff.newPc == PcW'($past(zPtr)) && !res_ff.flagsWrite ##1 done_ff)
        else $error("indirect jump target or timing wrong");
    ext_jump_pc_a: assert property (
        isTake && cmd.op == bfc_pkg::OP_EXTENDED_INDIRECT_JUMP |=>
        res_ff.newPc == PcW'({$past(extendedJumpPage), $past(zPtr)})
        ##1 done_ff)
        else $error("extended jump target or timing wrong");
    abs_jump_time_a: assert property (
        isTake && cmd.op == bfc_pkg::OP_ABSOLUTE_JUMP |=>
        (busy_ff && !done_ff)[*2] ##1 done_ff)
        else $error("absolute jump not three cycles");
    rel_call_pc_a: assert property (
        isTake && cmd.op == bfc_pkg::OP_RELATIVE_SUBROUTINE_ENTRY |=>
        res_ff.newPc == $past(pc) + PcW'($signed($past(cmd.offset))) + 1'b1
        ##3 done_ff)
        else $error("relative call target or timing wrong");
    abs_call_time_a: assert property (
        isTake && cmd.op == bfc_pkg::OP_ABSOLUTE_SUBROUTINE_ENTRY |=>
        (busy_ff && !done_ff)[*4] ##1 done_ff)
        else $error("absolute call not five cycles");
    exit_reload_a: assert property (
        isTake && (cmd.op == bfc_pkg::OP_SUBROUTINE_EXIT
        || cmd.op == bfc_pkg::OP_INTERRUPT_EXIT) |=>
        res_ff.newPc == $past(stackAddr) && res_ff.popRet ##4 done_ff)
        else $error("exit reload or timing wrong");
    int_exit_ie_a: assert property (
        isTake && cmd.op == bfc_pkg::OP_INTERRUPT_EXIT |=>
        res_ff.flags[7] && res_ff.flagsWrite)
        else $error("interrupt exit did not set enable");
    compare_one_cyc_a: assert property (
        isTake && cmd.op inside {bfc_pkg::OP_COMPARE_REGISTERS,
        bfc_pkg::OP_COMPARE_WITH_BORROW, bfc_pkg::OP_COMPARE_CONSTANT} |=>
        done_ff && res_ff.flagsWrite && res_ff.cycles == 3'h1)
        else $error("compare not one cycle with flag write");
    branch_flags_kept_a: assert property (
        isTake && cmd.op inside {[bfc_pkg::OP_BRANCH_FLAG_HIGH:
        bfc_pkg::OP_BRANCH_TBIT_LOW]} |=>
        !res_ff.flagsWrite && res_ff.flags == $past(statusFlagsRegister))
        else $error("branch altered status flags");
endmodule

// >>> verification/branch_flow_control_unit_tb_top.sv
`timescale 1ns/1ps
module branch_flow_control_unit_tb_top;
    logic clock, rst_b, start, poke;
    bfc_pkg::bfc_cmd_t cmd;
    logic [21:0] pc, stackAddr;
    logic [15:0] zPtr;
    logic [7:0] extendedJumpPage, statusFlagsRegister;
    logic busy_ff, done_ff;
    bfc_pkg::bfc_res_t res_ff;
    int fails, samples_checked, n;

    bfc_flow_unit #(.PcW(22)) u_bfc_flow_unit (
        .clock(clock), .rst_b(rst_b), .start(start), .cmd(cmd), .pc(pc),
        .zPtr(zPtr), .extendedJumpPage(extendedJumpPage),
        .statusFlagsRegister(statusFlagsRegister), .stackAddr(stackAddr),
        .busy_ff(busy_ff), .done_ff(done_ff), .res_ff(res_ff));

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task chk(input string what, input logic [63:0] seen,
             input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task results;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----------------------------------------
    // One operation: take, wait done, compare
    // ----------------------------------------
    task run(input bfc_pkg::bfc_op_t op, input logic [21:0] expPc,
             input logic [2:0] expCyc, input int expFw,
             input logic [7:0] expFl);
        cmd.op = op;
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        n = 1;
        while (done_ff !== 1'b1 && n < 12)
        begin
            if (poke)
                start = (n == 2);
            @(negedge clock);
            n++;
        end
        if (n >= 12)
        begin
            fails++;
            results();
        end
        else
        begin
            chk("newPc", res_ff.newPc, expPc);
            chk("cycles", res_ff.cycles, expCyc);
            chk("latency", n, expCyc);
            chk("flagsWrite", res_ff.flagsWrite, expFw);
            chk("flags", res_ff.flags, expFl);
            if (n == 1)
                @(negedge clock);
        end
    endtask

    function automatic logic [2:0] step(input logic tk);
        step = tk ? (cmd.nextTwoWord ? 3'h3 : 3'h2) : 3'h1;
    endfunction

    function automatic logic tk(input bfc_pkg::bfc_op_t op,
                                input logic [7:0] f, input logic [2:0] s);
        case (op)
            bfc_pkg::OP_BRANCH_FLAG_HIGH: tk = f[s];
            bfc_pkg::OP_BRANCH_FLAG_LOW: tk = !f[s];
            bfc_pkg::OP_BRANCH_ON_EQUAL: tk = f[1];
            bfc_pkg::OP_BRANCH_NOT_EQUAL: tk = !f[1];
            bfc_pkg::OP_BRANCH_CARRY_HIGH,
            bfc_pkg::OP_BRANCH_LOWER: tk = f[0];
            bfc_pkg::OP_BRANCH_NEGATIVE: tk = f[2];
            bfc_pkg::OP_BRANCH_POSITIVE: tk = !f[2];
            bfc_pkg::OP_BRANCH_GE_SIGNED: tk = !(f[2] ^ f[3]);
            bfc_pkg::OP_BRANCH_LT_SIGNED: tk = f[2] ^ f[3];
            bfc_pkg::OP_BRANCH_HALFCARRY_HIGH: tk = f[5];
            bfc_pkg::OP_BRANCH_HALFCARRY_LOW: tk = !f[5];
            bfc_pkg::OP_BRANCH_TBIT_HIGH: tk = f[6];
            bfc_pkg::OP_BRANCH_TBIT_LOW: tk = !f[6];
            default: tk = !f[0];
        endcase
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic t;
        fails = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        start = 1'b0;
        poke = 1'b0;
        cmd = '0;
        pc = 22'h001000;
        zPtr = 16'h1234;
        extendedJumpPage = 8'h05;
        statusFlagsRegister = 8'h5a;
        stackAddr = 22'h00abcd;
        repeat (8) @(negedge clock);
        rst_b = 1'b1;
        chk("busy", busy_ff, 64'h0);
        chk("done", done_ff, 64'h0);
        chk("res", res_ff, 64'h0);
        cmd.offset = 12'h800;
        cmd.target = 22'h2abcde;
        run(bfc_pkg::OP_REG_INDIRECT_JUMP, 22'h001234, 3'h2, 0, 8'h5a);
        run(bfc_pkg::OP_EXTENDED_INDIRECT_JUMP, 22'h051234, 3'h2, 0,
            8'h5a);
        run(bfc_pkg::OP_ABSOLUTE_JUMP, 22'h2abcde, 3'h3, 0, 8'h5a);
        run(bfc_pkg::OP_RELATIVE_SUBROUTINE_ENTRY, 22'h000801, 3'h4, 0,
            8'h5a);
        chk("retAddr", res_ff.retAddr, 22'h001001);
        chk("pushRet", res_ff.pushRet, 1'b1);
        run(bfc_pkg::OP_INDIRECT_SUBROUTINE_ENTRY, 22'h001234, 3'h4, 0,
            8'h5a);
        run(bfc_pkg::OP_EXTENDED_SUBROUTINE_ENTRY, 22'h051234, 3'h4, 0,
            8'h5a);
        poke = 1'b1;
        run(bfc_pkg::OP_ABSOLUTE_SUBROUTINE_ENTRY, 22'h2abcde, 3'h5, 0,
            8'h5a);
        poke = 1'b0;
        chk("retAddr", res_ff.retAddr, 22'h001002);
        run(bfc_pkg::OP_SUBROUTINE_EXIT, 22'h00abcd, 3'h5, 0, 8'h5a);
        chk("popRet", res_ff.popRet, 1'b1);
        run(bfc_pkg::OP_INTERRUPT_EXIT, 22'h00abcd, 3'h5, 1, 8'hda);
        // Compares: borrow, borrow-in, overflow, sticky zero
        statusFlagsRegister = 8'h00;
        cmd.regD = 8'h10;
        cmd.regR = 8'h20;
        run(bfc_pkg::OP_COMPARE_REGISTERS, 22'h001001, 3'h1, 1, 8'h05);
        statusFlagsRegister = 8'h03;
        cmd.regD = 8'h20;
        run(bfc_pkg::OP_COMPARE_WITH_BORROW, 22'h001001, 3'h1, 1,
            8'h25);
        statusFlagsRegister = 8'h00;
        cmd.regD = 8'h80;
        cmd.constVal = 8'h01;
        run(bfc_pkg::OP_COMPARE_CONSTANT, 22'h001001, 3'h1, 1, 8'h28);
        statusFlagsRegister = 8'h02;
        cmd.regD = 8'h33;
        cmd.regR = 8'h33;
        run(bfc_pkg::OP_COMPARE_WITH_BORROW, 22'h001001, 3'h1, 1,
            8'h02);
        for (int i = 0; i < 3; i++)
        begin
            cmd.nextTwoWord = i[0];
            cmd.regR = (i == 2) ? 8'h34 : 8'h33;
            t = (i != 2);
            run(bfc_pkg::OP_EQUAL_COMPARE_SKIP, pc + step(t), step(t), 0,
                8'h02);
        end
        for (int b = 0; b < 8; b++)
        begin
            cmd.bitSel = b[2:0];
            cmd.regD = 8'ha5;
            cmd.regR = 8'ha5;
            cmd.nextTwoWord = b[0];
            cmd.ioBit = b[1];
            t = !cmd.regR[b];
            run(bfc_pkg::OP_SKIP_REG_BIT_LOW, pc + step(t), step(t), 0,
                8'h02);
            run(bfc_pkg::OP_SKIP_REG_BIT_HIGH, pc + step(!t), step(!t), 0,
                8'h02);
            run(bfc_pkg::OP_SKIP_IO_BIT_LOW, pc + step(!b[1]), step(!b[1]), 0,
                8'h02);
            run(bfc_pkg::OP_SKIP_IO_BIT_HIGH, pc + step(b[1]), step(b[1]), 0,
                8'h02);
        end
        cmd.offset = 12'h7ff;
        for (int i = 17; i < 33; i++)
        begin
            for (int v = 0; v < 16; v++)
            begin
                cmd.bitSel = v[2:0];
                statusFlagsRegister = v[3] ? ~(8'h01 << v[2:0])
                                           : (8'h01 << v[2:0]);
                t = tk(bfc_pkg::bfc_op_t'(i), statusFlagsRegister, v[2:0]);
                run(bfc_pkg::bfc_op_t'(i), t ? 22'h001800 : 22'h001001,
                    t ? 3'h2 : 3'h1, 0, statusFlagsRegister);
            end
        end
        results();
    end
endmodule

bind bfc_flow_unit bfc_flow_checker #(.PcW(PcW)) u_bfc_flow_checker (
    .clock(clock), .rst_b(rst_b), .start(start), .cmd(cmd), .pc(pc),
    .zPtr(zPtr), .extendedJumpPage(extendedJumpPage),
    .statusFlagsRegister(statusFlagsRegister), .stackAddr(stackAddr),
    .busy_ff(busy_ff), .done_ff(done_ff), .res_ff(res_ff));
